// >>> rtl/wscr_bank.sv
/*
 * Wake source control register bank behind an AXI4-Lite slave: internal
 * wake control, external wake control, wake input pull control, the low
 * stop-mode watchdog bit of the watchdog control register, and a small
 * sticky interrupt block. Assumes a single 40 MHz clock, synchronous
 * active-low reset, and one-cycle event pulses from the device core.
 */
// What this block does
// [RL1] Bit 7 enables second timer as wake
// [RL2] Bit 6 enables first timer as wake
// [RL3] Bit 2 is high stop-watchdog-off bit, hardware-updatable
// [RL4] Watchdog control bit 6 is low stop-watchdog-off bit
// [RL5] Reserved bits always read zero
// [RL6] Internal wake: reset zero, restart keeps timers
// [RL7] External wake: reset 0x07, restart keeps x bits
// [RL8] Pull control: reset zero, restart clears 7:6
// [RL9] Global bit selects wake-only or all-status interrupt
// [RL10] Measurement select ignores input one/two enables
// [RL11] Measurement runs in Normal mode; levels meaningless
// [RL12] Bits 2:0 enable wake inputs three, two, one
// [RL13] Host makes CAN a wake source elsewhere
// [RL14] Fail-safe entry forces wake-enabling values
// [RL15] Two-bit pull fields select none/down/up/auto
// [RL16] Registers decode at indices 6, 7, 8
// [RL17] Writes to reserved bits change nothing
`timescale 1ns/1ps
module wscr_bank
    import wscr_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,

    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,

    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,

    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,

    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,

    // Device core events and mode
    input wire logic soft_reset,
    input wire logic restart_entry,
    input wire logic failsafe_entry,
    input wire logic normal_mode,
    input wire logic other_status_event,
    input wire logic [4:0] wake_request,
    input wire logic stop_watchdog_load,
    input wire logic [1:0] stop_watchdog_value,

    // Configuration outputs
    output logic second_timer_wake_enable,
    output logic first_timer_wake_enable,
    output logic input_three_wake_enable,
    output logic input_two_wake_enable,
    output logic input_one_wake_enable,
    output logic [1:0] stop_watchdog_off,
    output logic measurement_run,
    output logic level_status_valid,
    output logic [1:0] input_three_pull_select,
    output logic [1:0] input_two_pull_select,
    output logic [1:0] input_one_pull_select,
    output logic bus_wake_force,

    // Interrupt
    output logic irq
);

    // Stored registers
    logic [7:0] internal_wake_control_ff; // Timer enables, high watchdog bit
    logic [7:0] external_wake_control_ff; // Global irq, measurement, input enables
    logic [7:0] wake_input_pull_control_ff; // Three pull fields
    logic [7:0] watchdog_control_ff; // Only the low watchdog bit lives here
    logic [IRQ_WIDTH-1:0] irq_status_ff; // Sticky event bits
    logic [IRQ_WIDTH-1:0] irq_enable_ff; // Event mask

    // Next-state values
    logic [7:0] nxt_internal;
    logic [7:0] nxt_external;
    logic [7:0] nxt_pull;
    logic [7:0] nxt_watchdog;
    logic [IRQ_WIDTH-1:0] nxt_irq_status;
    logic [IRQ_WIDTH-1:0] nxt_irq_enable;

    // Bus handshake state
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic bus_wake_force_ff;

    // Write decode
    // A held response stalls writes
    wire write_fire = awvalid & wvalid & ~bvalid_ff;
    // Registers use byte lane 0
    wire lane0 = wstrb[0];
    wire [7:0] wbyte = wdata[7:0];

    // Bus byte address compared against register byte addresses; low bits must be zero
    wire wr_int = write_fire & (awaddr == wscr_addr(IDX_INTERNAL_WAKE)); // [RL16]
    wire wr_ext = write_fire & (awaddr == wscr_addr(IDX_EXTERNAL_WAKE)); // [RL16]
    wire wr_pull = write_fire & (awaddr == wscr_addr(IDX_PULL_CONTROL)); // [RL16]
    wire wr_wd = write_fire & (awaddr == wscr_addr(IDX_WATCHDOG_CONTROL));
    wire wr_ien = write_fire & (awaddr == wscr_addr(IDX_IRQ_ENABLE));
    wire wr_iclr = write_fire & (awaddr == wscr_addr(IDX_IRQ_CLEAR));
    wire wr_ista = write_fire & (awaddr == wscr_addr(IDX_IRQ_STATUS));

    // Status is read-only but a write to it is still answered OKAY
    wire wr_hit = wr_int | wr_ext | wr_pull | wr_wd | wr_ien | wr_iclr | wr_ista;

    // Read decode
    // One read at a time
    wire read_fire = arvalid & ~rvalid_ff;

    wire rd_int = (araddr == wscr_addr(IDX_INTERNAL_WAKE)); // [RL16]
    wire rd_ext = (araddr == wscr_addr(IDX_EXTERNAL_WAKE)); // [RL16]
    wire rd_pull = (araddr == wscr_addr(IDX_PULL_CONTROL)); // [RL16]
    wire rd_wd = (araddr == wscr_addr(IDX_WATCHDOG_CONTROL));
    wire rd_ista = (araddr == wscr_addr(IDX_IRQ_STATUS));
    wire rd_ien = (araddr == wscr_addr(IDX_IRQ_ENABLE));
    wire rd_iclr = (araddr == wscr_addr(IDX_IRQ_CLEAR));

    // Clear register is write-only and reads as zero, but is mapped
    wire rd_hit = rd_int | rd_ext | rd_pull | rd_wd | rd_ista | rd_ien | rd_iclr;

    // Reserved bits read zero because storage never sets them; unused upper bits are zero-padded
    wire [7:0] rd_byte = rd_int ? internal_wake_control_ff : // [RL5]
                         rd_ext ? external_wake_control_ff :
                         rd_pull ? wake_input_pull_control_ff :
                         rd_wd ? watchdog_control_ff :
                         rd_ista ? {4'h0, irq_status_ff} :
                         rd_ien ? {4'h0, irq_enable_ff} : 8'h00;

    // Handshake outputs are combinational; address and data taken together
    assign awready = write_fire;
    assign wready = write_fire;
    assign arready = ~rvalid_ff;

    // Responses come from flops
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // Field views
    wire meas_sel = external_wake_control_ff[BIT_MEAS_SELECT];
    wire int_global = external_wake_control_ff[BIT_INT_GLOBAL];
    // Masked lane gives zero
    wire [7:0] wbyte_valid = lane0 ? wbyte : 8'h00;

    // Next value of internal wake control: restart, then bus, then hardware
    always_comb begin
        nxt_internal = internal_wake_control_ff;
        if (restart_entry) begin
            // Only timer enables survive
            nxt_internal = internal_wake_control_ff & KEEP_RESTART_INTERNAL; // [RL6]
        end else if (wr_int && lane0) begin
            // Only timer enables and high watchdog bit take data
            nxt_internal = wscr_merge(internal_wake_control_ff, wbyte_valid,
                                      WMASK_INTERNAL); // [RL17] [RL1] [RL2]
        end

        // Hardware update wins over a bus write in the same cycle
        if (stop_watchdog_load) begin
            nxt_internal[BIT_STOP_WD_OFF_HIGH] = stop_watchdog_value[1]; // [RL3]
        end
    end

    // Next value of external wake control; fail-safe has top priority
    always_comb begin
        nxt_external = external_wake_control_ff;
        if (failsafe_entry) begin
            // Keep 7, 5; force 2:0 on
            nxt_external = (external_wake_control_ff & KEEP_FAILSAFE_EXTERNAL
                            & WMASK_EXTERNAL) | SET_FAILSAFE_EXTERNAL; // [RL14]
        end else if (restart_entry) begin
            // Restart keeps 7, 5 and 2:0
            nxt_external = external_wake_control_ff & KEEP_RESTART_EXTERNAL; // [RL7]
        end else if (wr_ext && lane0) begin
            nxt_external = wscr_merge(external_wake_control_ff, wbyte_valid,
                                      WMASK_EXTERNAL); // [RL17] [RL12]
        end
    end

    // Next value of pull control
    always_comb begin
        nxt_pull = wake_input_pull_control_ff;
        if (restart_entry) begin
            // Pull fields survive restart
            nxt_pull = wake_input_pull_control_ff & KEEP_RESTART_PULL; // [RL8]
        end else if (wr_pull && lane0) begin
            nxt_pull = wscr_merge(wake_input_pull_control_ff, wbyte_valid,
                                  WMASK_PULL); // [RL17] [RL15]
        end
    end

    // Next value of the watchdog control slice
    always_comb begin
        nxt_watchdog = watchdog_control_ff;
        if (restart_entry) begin
            // Low watchdog bit clears
            nxt_watchdog = watchdog_control_ff & KEEP_RESTART_WATCHDOG;
        end else if (wr_wd && lane0) begin
            nxt_watchdog = wscr_merge(watchdog_control_ff, wbyte_valid,
                                      WMASK_WATCHDOG); // [RL4] [RL17]
        end

        // Load beats a bus write
        if (stop_watchdog_load) begin
            nxt_watchdog[BIT_STOP_WD_OFF_LOW] = stop_watchdog_value[0]; // [RL4]
        end
    end

    // Wake sources, with measurement mode masking inputs one and two
    // Stored enables stay readable
    assign second_timer_wake_enable = internal_wake_control_ff[BIT_SECOND_TIMER_WAKE]; // [RL1]
    assign first_timer_wake_enable = internal_wake_control_ff[BIT_FIRST_TIMER_WAKE]; // [RL2]
    assign input_three_wake_enable = external_wake_control_ff[BIT_INPUT_THREE_WAKE]; // [RL12]
    assign input_two_wake_enable = external_wake_control_ff[BIT_INPUT_TWO_WAKE]
                                   & ~meas_sel; // [RL10]
    assign input_one_wake_enable = external_wake_control_ff[BIT_INPUT_ONE_WAKE]
                                   & ~meas_sel; // [RL10]
    assign stop_watchdog_off = {internal_wake_control_ff[BIT_STOP_WD_OFF_HIGH],
                                watchdog_control_ff[BIT_STOP_WD_OFF_LOW]}; // [RL3] [RL4]

    // Measurement voids levels
    assign measurement_run = meas_sel & normal_mode; // [RL11]
    assign level_status_valid = ~meas_sel; // [RL11]

    // Pull codes go to the pads
    assign input_three_pull_select = wake_input_pull_control_ff[POS_INPUT_THREE_PULL +: 2]; // [RL15]
    assign input_two_pull_select = wake_input_pull_control_ff[POS_INPUT_TWO_PULL +: 2]; // [RL15]
    assign input_one_pull_select = wake_input_pull_control_ff[POS_INPUT_ONE_PULL +: 2]; // [RL15]

    // Bus control itself is outside; this pulse tells it to take its wake value
    assign bus_wake_force = bus_wake_force_ff; // [RL14]

    // A wake request counts only from an enabled source
    // Order of wake_request: second timer, first timer, input three, two, one
    wire [4:0] wake_gate = {second_timer_wake_enable, first_timer_wake_enable,
                            input_three_wake_enable, input_two_wake_enable,
                            input_one_wake_enable};
    // Any enabled source wakes
    wire wake_event = |(wake_request & wake_gate);

    // Events of this cycle, by status bit
    wire [IRQ_WIDTH-1:0] irq_event = {restart_entry, failsafe_entry,
                                      other_status_event, wake_event};
    wire [IRQ_WIDTH-1:0] irq_clear = (wr_iclr && lane0) ? wbyte[IRQ_WIDTH-1:0] :
                                     {IRQ_WIDTH{1'b0}};

    // Set wins over a clear in the same cycle, so no event is lost
    assign nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_event;
    assign nxt_irq_enable = (wr_ien && lane0) ? wbyte[IRQ_WIDTH-1:0] : irq_enable_ff;

    // Without the global bit only the wake status may raise the line
    // Level output, no pulse
    wire [IRQ_WIDTH-1:0] irq_policy = int_global ? {IRQ_WIDTH{1'b1}} :
                                      {{(IRQ_WIDTH-1){1'b0}}, 1'b1}; // [RL9]
    assign irq = |(irq_status_ff & irq_enable_ff & irq_policy); // [RL9]

    // Configuration registers; soft reset behaves like power-on reset
    // Soft reset is sampled like aresetn
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            internal_wake_control_ff <= RST_INTERNAL; // [RL6]
            external_wake_control_ff <= RST_EXTERNAL; // [RL7]
            wake_input_pull_control_ff <= RST_PULL; // [RL8]
            watchdog_control_ff <= RST_WATCHDOG;
        end else begin
            internal_wake_control_ff <= nxt_internal;
            external_wake_control_ff <= nxt_external;
            wake_input_pull_control_ff <= nxt_pull;
            watchdog_control_ff <= nxt_watchdog;
        end
    end

    // Interrupt registers; only the bus reset clears them
    // Pending events outlive soft reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_ff <= {IRQ_WIDTH{1'b0}};
            irq_enable_ff <= RST_IRQ_ENABLE;
            bus_wake_force_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_enable_ff <= nxt_irq_enable;
            bus_wake_force_ff <= failsafe_entry;
        end
    end

    // Write response: one cycle after acceptance, held until bready
    // SLVERR marks unmapped writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (write_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read data: one cycle after acceptance, held until rready
    // Unmapped reads return zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (read_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rd_byte};
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule // wscr_bank

// >>> rtl/wscr_pkg.sv
/*
 * Constants for the wake source control register bank: register indices,
 * bus byte addresses, bit positions, reset, restart and fail-safe values.
 * Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
 */
package wscr_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [5:0] IDX_WATCHDOG_CONTROL = 6'h03;
    localparam logic [5:0] IDX_INTERNAL_WAKE = 6'h06;
    localparam logic [5:0] IDX_EXTERNAL_WAKE = 6'h07;
    localparam logic [5:0] IDX_PULL_CONTROL = 6'h08;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h11;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h12;

    // Bit positions
    localparam int BIT_SECOND_TIMER_WAKE = 7;
    localparam int BIT_FIRST_TIMER_WAKE = 6;
    localparam int BIT_STOP_WD_OFF_HIGH = 2;
    localparam int BIT_STOP_WD_OFF_LOW = 6;
    localparam int BIT_INT_GLOBAL = 7;
    localparam int BIT_MEAS_SELECT = 5;
    localparam int BIT_INPUT_THREE_WAKE = 2;
    localparam int BIT_INPUT_TWO_WAKE = 1;
    localparam int BIT_INPUT_ONE_WAKE = 0;
    localparam int POS_INPUT_THREE_PULL = 4;
    localparam int POS_INPUT_TWO_PULL = 2;
    localparam int POS_INPUT_ONE_PULL = 0;

    // Implemented (writable) bits; every other bit is reserved and reads zero
    localparam logic [7:0] WMASK_INTERNAL = 8'hc4;
    localparam logic [7:0] WMASK_EXTERNAL = 8'ha7;
    localparam logic [7:0] WMASK_PULL = 8'h3f;
    localparam logic [7:0] WMASK_WATCHDOG = 8'h40;

    // Power-on / soft reset values
    localparam logic [7:0] RST_INTERNAL = 8'h00;
    localparam logic [7:0] RST_EXTERNAL = 8'h07;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_WATCHDOG = 8'h00;

    // Restart: bits set in a keep mask hold their value, the rest clear
    localparam logic [7:0] KEEP_RESTART_INTERNAL = 8'hc0;
    localparam logic [7:0] KEEP_RESTART_EXTERNAL = 8'ha7;
    localparam logic [7:0] KEEP_RESTART_PULL = 8'h3f;
    localparam logic [7:0] KEEP_RESTART_WATCHDOG = 8'h00;

    // Fail-safe entry on the external wake register: keep 7, 5, 4; force 2:0
    localparam logic [7:0] KEEP_FAILSAFE_EXTERNAL = 8'hb0;
    localparam logic [7:0] SET_FAILSAFE_EXTERNAL = 8'h07;

    // Interrupt status bits
    localparam int IRQ_WIDTH = 4;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_OTHER_STATUS = 1;
    localparam int IRQ_FAILSAFE = 2;
    localparam int IRQ_RESTART = 3;
    localparam logic [IRQ_WIDTH-1:0] RST_IRQ_ENABLE = 4'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Byte address of a register index
    function automatic logic [7:0] wscr_addr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    // Apply bus data to a register only in its implemented bits
    function automatic logic [7:0] wscr_merge(input logic [7:0] old_val,
                                              input logic [7:0] data,
                                              input logic [7:0] wmask);
        return (old_val & ~wmask) | (data & wmask);
    endfunction
endpackage

// >>> verification/wscr_host.sv
/*
 * Host model: an AXI4-Lite master with one write and one read task.
 * Assumes the caller enters each task just after a rising edge of aclk.
 */
`timescale 1ns/1ps
module wscr_host (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic awvalid,
    output logic [7:0] awaddr,
    output logic wvalid,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic bready,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    // Read channels
    output logic arvalid,
    output logic [7:0] araddr,
    output logic rready,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // Idle bus; response readies stay high so every answer retires at once
    initial begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
    end
    // Write one word and wait for its response
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        // Released lines show garbage, so a late sample cannot pass
        awaddr <= ~a;
        wdata <= ~{24'h0, d};
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask
    // Read one word
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
endmodule // wscr_host

// >>> verification/wscr_bank_assertions.sv
/*
 * Concurrent checks on the register bank ports.
 * Assumes one clock and the synchronous active-low reset.
 */
`timescale 1ns/1ps
module wscr_bank_checker (
    // Clock, reset and bus handshakes
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic bvalid,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    // Core events
    input wire logic soft_reset,
    input wire logic restart_entry,
    input wire logic failsafe_entry,
    input wire logic normal_mode,
    input wire logic stop_watchdog_load,
    input wire logic [1:0] stop_watchdog_value,
    // Configuration outputs
    input wire logic second_timer_wake_enable,
    input wire logic first_timer_wake_enable,
    input wire logic input_three_wake_enable,
    input wire logic input_two_wake_enable,
    input wire logic input_one_wake_enable,
    input wire logic [1:0] stop_watchdog_off,
    input wire logic measurement_run,
    input wire logic level_status_valid,
    input wire logic [1:0] input_three_pull_select,
    input wire logic bus_wake_force
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (awready |=> bvalid)
        else $error("write not answered in one cycle");
    a_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
        else $error("read late or upper bits set");
    a_meas_gating: assert property (!level_status_valid |-> !input_two_wake_enable && !input_one_wake_enable)
        else $error("input enables live under measurement");
    a_meas_normal: assert property (measurement_run == (!level_status_valid && normal_mode))
        else $error("measurement run mismatch");
    a_failsafe_force: assert property (failsafe_entry && !soft_reset |=> input_three_wake_enable && bus_wake_force)
        else $error("fail-safe did not force wake");
    // A bus write in the same cycle is left out, though restart already wins over its data
    a_restart_keep: assert property (restart_entry && !soft_reset && !awready && !stop_watchdog_load |=> $stable({second_timer_wake_enable, first_timer_wake_enable, input_three_pull_select}))
        else $error("restart lost kept bits");
    a_restart_clear: assert property (restart_entry && !soft_reset && !stop_watchdog_load |=> stop_watchdog_off == 2'b00)
        else $error("restart kept watchdog bits");
    a_soft_defaults: assert property (soft_reset && !stop_watchdog_load |=> !second_timer_wake_enable && !first_timer_wake_enable && input_three_wake_enable && input_three_pull_select == 2'b00 && stop_watchdog_off == 2'b00)
        else $error("soft reset values wrong");
    a_watchdog_load: assert property (stop_watchdog_load && !soft_reset |=> stop_watchdog_off == $past(stop_watchdog_value))
        else $error("watchdog load not taken");
endmodule // wscr_bank_checker
bind wscr_bank wscr_bank_checker u_wscr_bank_checker (.aclk, .aresetn, .awready, .arvalid,
    .arready, .bvalid, .rvalid, .rdata, .soft_reset, .restart_entry, .failsafe_entry,
    .normal_mode, .stop_watchdog_load, .stop_watchdog_value, .second_timer_wake_enable,
    .first_timer_wake_enable, .input_three_wake_enable, .input_two_wake_enable,
    .input_one_wake_enable, .stop_watchdog_off, .measurement_run, .level_status_valid,
    .input_three_pull_select, .bus_wake_force);

// >>> verification/tb_wscr_bank.sv
/*
 * Self-checking bench for the wake source control register bank.
 * Assumes the host model drives the bus; core events come from here.
 */
`timescale 1ns/1ps
module tb_wscr_bank;
    // Byte addresses: external, pull, status, enable, clear and one unmapped word
    localparam logic [7:0] A_EXT = 8'h1c, A_PULL = 8'h20, A_STAT = 8'h40;
    localparam logic [7:0] A_EN = 8'h44, A_CLR = 8'h48, A_HOLE = 8'h2c;
    // Watchdog, internal, external, pull: reset, all-ones and restart images
    logic [7:0] adr [4] = '{8'h0c, 8'h18, 8'h1c, 8'h20};
    logic [7:0] por [4] = '{8'h00, 8'h00, 8'h07, 8'h00};
    logic [7:0] ones [4] = '{8'h40, 8'hc4, 8'ha7, 8'h3f};
    logic [7:0] rst [4] = '{8'h00, 8'hc0, 8'ha7, 8'h3f};
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp, stop_watchdog_off;
    // Event pulses: soft, restart, fail-safe, other, watchdog load, wake one
    logic [5:0] ev = 6'h00;
    logic normal_mode = 1'b1;
    logic [1:0] stop_watchdog_value = 2'b11;
    wire soft_reset = ev[0], restart_entry = ev[1], failsafe_entry = ev[2];
    wire other_status_event = ev[3], stop_watchdog_load = ev[4];
    wire [4:0] wake_request = {4'h0, ev[5]};
    logic second_timer_wake_enable, first_timer_wake_enable, input_three_wake_enable;
    logic input_two_wake_enable, input_one_wake_enable, measurement_run, level_status_valid;
    logic [1:0] input_three_pull_select, input_two_pull_select, input_one_pull_select;
    logic bus_wake_force, irq;
    int mismatches = 0, n_checks = 0;
    // Gathered outputs so one compare covers timers, inputs, mode and watchdog
    wire [8:0] outs = {second_timer_wake_enable, first_timer_wake_enable,
        input_three_wake_enable, input_two_wake_enable, input_one_wake_enable,
        measurement_run, level_status_valid, stop_watchdog_off};
    always #12.5 aclk = ~aclk;
    wscr_bank u_wscr_bank (.*);
    wscr_host u_wscr_host (.*);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        u_wscr_host.rd(a, rd_data, resp);
        chk("read data", {24'h0, e}, rd_data);
        chk("read response", {30'h0, er}, {30'h0, resp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_wscr_host.wr(a, d, resp);
        chk("write response", 32'h0, {30'h0, resp});
    endtask
    // One-cycle event pulse, then one more edge so its effect has landed
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= 6'h00;
        @(posedge aclk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            rc(adr[i], por[i], 2'b00);
        end
        // All ones: reserved bits must stay zero
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], 8'hff);
            rc(adr[i], ones[i], 2'b00);
        end
        chk("outputs", 32'h1cb, {23'h0, outs});
        normal_mode <= 1'b0;
        pulse(6'h02);
        chk("restart outputs", 32'h1c0, {23'h0, outs});
        for (int i = 0; i < 4; i++) begin
            rc(adr[i], rst[i], 2'b00);
        end
        pulse(6'h10);
        rc(adr[1], 8'hc4, 2'b00);
        rc(adr[0], 8'h40, 2'b00);
        stop_watchdog_value <= 2'b00;
        pulse(6'h10);
        chk("watchdog off", 32'h0, {30'h0, stop_watchdog_off});
        for (int i = 0; i < 3; i++) begin
            wr(A_EXT, 8'(1 << i));
            chk("wake enables", 32'(1 << i), {29'h0, outs[6:4]});
        end
        for (int k = 0; k < 4; k++) begin
            wr(A_PULL, {2'b00, k[1:0], k[1:0], k[1:0]});
            chk("pulls", {26'h0, k[1:0], k[1:0], k[1:0]}, {26'h0, input_three_pull_select,
                input_two_pull_select, input_one_pull_select});
        end
        wr(A_EXT, 8'ha0);
        pulse(6'h04);
        rc(A_EXT, 8'ha7, 2'b00);
        rc(A_HOLE, 8'h00, 2'b10);
        u_wscr_host.wr(A_HOLE, 8'hff, resp);
        chk("unmapped write", 32'h2, {30'h0, resp});
        // Interrupt: clear, enable, policy, mask and clear again
        wr(A_CLR, 8'h0f);
        rc(A_STAT, 8'h00, 2'b00);
        wr(A_EXT, 8'h01);
        wr(A_EN, 8'h0f);
        pulse(6'h08);
        chk("irq wake only", 32'h0, {31'h0, irq});
        wr(A_EXT, 8'h81);
        chk("irq global", 32'h1, {31'h0, irq});
        wr(A_EN, 8'h01);
        chk("irq masked", 32'h0, {31'h0, irq});
        pulse(6'h20);
        chk("irq wake", 32'h1, {31'h0, irq});
        rc(A_STAT, 8'h03, 2'b00);
        wr(A_CLR, 8'h01);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(A_EXT, 8'h21);
        pulse(6'h20);
        chk("irq measured", 32'h0, {31'h0, irq});
        pulse(6'h01);
        for (int i = 0; i < 4; i++) begin
            rc(adr[i], por[i], 2'b00);
        end
        report_and_stop();
    end
endmodule // tb_wscr_bank
